// *** logic/rwc_params.svh ***
`ifndef RWC_PARAMS_SVH
`define RWC_PARAMS_SVH

// Remote word register indices
`define RW_MONITOR_SELECT_1_2 3'h0
`define RW_SPEED_OR_TORQUE 3'h1
`define RW_INSTRUCTION_WORD 3'h2
`define RW_INSTRUCTION_OPERAND 3'h3
`define RW_MONITOR_SELECT_3 3'h4
`define RW_MONITOR_SELECT_4 3'h5
`define RW_MONITOR_SELECT_5 3'h6
`define RW_MONITOR_SELECT_6 3'h7
`define RW_RESET_VALUE 16'h0000

// Field positions inside words
`define CODE_LO_MSB 7
`define CODE_LO_LSB 0
`define CODE_HI_MSB 15
`define CODE_HI_LSB 8
`define WRITE_FLAG_BIT 7
`define PARAM_ADDR_MSB 6

// Extended setting and torque source values
`define EXT_ZERO_A 16'h0000
`define EXT_ZERO_B 16'h0064
`define EXT_TORQUE_A 16'h0000
`define EXT_TORQUE_B 16'h0001
`define EXT_TORQUE_C 16'h000C
`define SRC_TORQUE_A 16'h0003
`define SRC_TORQUE_B 16'h0005

// Instruction codes
`define CMD_OPMODE_READ 8'h7D
`define CMD_OPMODE_WRITE 8'hFD
`define CMD_ERROR_REFER 8'h7E
`define CMD_ERROR_CLEAR 8'hFE

// Parameter addresses held in flip-flops
`define PA_EXTENDED_SETTING 7'h01
`define PA_TORQUE_SOURCE 7'h02
`define PA_TORQUE_RAM 7'h03
`define PA_TORQUE_RAM_NVM 7'h04
`define PA_SET_FREQUENCY 7'h05
`define PA_OPMODE 7'h7F

// Reset values
`define EXT_RESET 16'h0000
`define SRC_RESET 16'h0000
`define OPMODE_RESET 16'h0000
`define PARAM_RESET 16'h0000

`endif

// *** logic/rwc_pkg.sv ***
package rwc_pkg;

  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic [15:0] data;
  } word_write_s;

  typedef struct packed {
    logic strobe;
    logic [6:0] addr;
    logic [15:0] data;
  } nvm_write_s;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_SETPOINT = 5'b00010,
    ST_EXECUTE = 5'b00100,
    ST_READ_WAIT = 5'b01000,
    ST_FINISH = 5'b10000
  } handler_state_e;

endpackage

// *** logic/param_store.sv ***
`timescale 1ns/1ps
module param_store #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock
  input wire logic core_clk,
  // Write port
  input wire logic write_enable,
  input wire logic [AW-1:0] write_addr,
  input wire logic [WIDTH-1:0] write_data,
  // Read port, data one cycle after the address
  input wire logic [AW-1:0] read_addr,
  output logic [WIDTH-1:0] read_data
);

  logic [WIDTH-1:0] cells [DEPTH];

  always_ff @(posedge core_clk)
  begin
    if (write_enable)
    begin
      cells[write_addr] <= write_data;
    end
  end

  always_ff @(posedge core_clk)
  begin
    read_data <= cells[read_addr];
  end

endmodule

// *** logic/monitor_fill.sv ***
`timescale 1ns/1ps
`include "rwc_params.svh"
module monitor_fill #(
  parameter int ITEMS = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Selection
  input wire logic monitor_request,
  input wire logic [15:0] monitor_select_1_2,
  input wire logic [15:0] monitor_select_3,
  input wire logic [15:0] monitor_select_4,
  input wire logic [15:0] monitor_select_5,
  input wire logic [15:0] monitor_select_6,
  input wire logic [ITEMS*16-1:0] monitor_items,
  // Results
  output logic [15:0] monitor_result_1,
  output logic [15:0] monitor_result_2,
  output logic [15:0] monitor_result_5,
  output logic [15:0] monitor_result_6,
  output logic [15:0] monitor_result_7,
  output logic [15:0] monitor_result_8,
  output logic monitoring_flag
);

  // Unknown codes read as zero
  function automatic logic [15:0] item_at(input logic [15:0] code, input logic [ITEMS*16-1:0] items);
    logic [15:0] value;
    value = 16'h0000;
    for (int i = 0; i < ITEMS; i++)
    begin
      if (code == 16'(i))
      begin
        value = items[i*16 +: 16];
      end
    end
    return value;
  endfunction

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      monitor_result_1 <= 16'h0000;
      monitor_result_2 <= 16'h0000;
      monitor_result_5 <= 16'h0000;
      monitor_result_6 <= 16'h0000;
      monitor_result_7 <= 16'h0000;
      monitor_result_8 <= 16'h0000;
    end
    else if (monitor_request)
    begin
      monitor_result_1 <= item_at({8'h00, monitor_select_1_2[`CODE_LO_MSB:`CODE_LO_LSB]}, monitor_items); // [R1]
      monitor_result_2 <= item_at({8'h00, monitor_select_1_2[`CODE_HI_MSB:`CODE_HI_LSB]}, monitor_items); // [R1]
      monitor_result_5 <= item_at(monitor_select_3, monitor_items); // [R12]
      monitor_result_6 <= item_at(monitor_select_4, monitor_items); // [R12]
      monitor_result_7 <= item_at(monitor_select_5, monitor_items); // [R12]
      monitor_result_8 <= item_at(monitor_select_6, monitor_items); // [R12]
    end
  end

  // Flag rises one cycle after the first refresh, drops with the request
  logic refreshed;

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      refreshed <= 1'b0;
      monitoring_flag <= 1'b0;
    end
    else
    begin
      refreshed <= monitor_request;
      monitoring_flag <= monitor_request && refreshed; // [R13]
    end
  end

endmodule

// *** logic/remote_word_command_handler.sv ***
// What this block does
// (R1) Monitor request fills results 1 and 2 from the two codes of word 0.
// (R2) Setpoint goes to RAM on RAM write, to RAM and NVM on NVM write.
// (R3) After the write, raise the done flag matching the write request used.
// (R4) Master sends frequency as hundredths of a hertz, 0 to 59000.
// (R5) Extended 0, 1 or 12 with torque source 3 or 5 selects torque command.
// (R6) A torque write updates both torque parameters in one operation.
// (R7) Master loads the instruction before execute; device then runs it.
// (R8) Raise the execute done flag after the instruction has run.
// (R9) With nonzero extended setting, instruction upper byte is link extended setting. The code drives 0 for setting 100 as well.
// (R10) Master loads operand and instruction before raising execute.
// (R11) Master loads zero operand when the instruction needs none.
// (R12) Monitor request fills results 5 to 8 from monitor codes 3 to 6.
// (R13) Monitoring flag rises after results are valid, drops with the request.
// (R14) Each done flag clears when its request drops.
// (R15) Each remote word is 16 bits and holds until overwritten.
`timescale 1ns/1ps
`include "rwc_params.svh"
module remote_word_command_handler #(
  parameter int ITEMS = 16,
  parameter int PARAM_DEPTH = 128
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Remote word writes from the master
  input rwc_pkg::word_write_s word_write,
  // Request bits from the master
  input wire logic monitor_request,
  input wire logic ram_write_request,
  input wire logic ram_nvm_write_request,
  input wire logic execute_request,
  // Device state
  input wire logic [ITEMS*16-1:0] monitor_items,
  input wire logic [15:0] fault_code,
  // Monitor results
  output logic [15:0] monitor_result_1,
  output logic [15:0] monitor_result_2,
  output logic [15:0] monitor_result_5,
  output logic [15:0] monitor_result_6,
  output logic [15:0] monitor_result_7,
  output logic [15:0] monitor_result_8,
  output logic monitoring_flag,
  // Completion flags
  output logic ram_write_done,
  output logic ram_nvm_write_done,
  output logic execute_done,
  // Instruction results
  output logic [15:0] instruction_reply,
  output logic [7:0] link_extended_setting,
  // Device controls
  output logic [15:0] set_frequency,
  output logic [15:0] torque_ram_param,
  output logic [15:0] torque_ram_nvm_param,
  output logic [15:0] operation_mode,
  output logic fault_reset,
  output rwc_pkg::nvm_write_s nvm_write
);

  logic [15:0] monitor_select_1_2;
  logic [15:0] speed_or_torque_setpoint;
  logic [15:0] instruction_word;
  logic [15:0] instruction_operand;
  logic [15:0] monitor_select_3;
  logic [15:0] monitor_select_4;
  logic [15:0] monitor_select_5;
  logic [15:0] monitor_select_6;
  logic [15:0] extended_setting_param;
  logic [15:0] torque_source_param;
  rwc_pkg::handler_state_e state;
  rwc_pkg::handler_state_e next_state;
  logic setpoint_to_nvm;
  logic torque_mode;
  logic [7:0] opcode;
  logic [6:0] param_addr;
  logic store_we;
  logic [15:0] store_rdata;
  logic execute_flow;

  // Extended setting 0 and 100 both mean the plain layout
  function automatic logic ext_is_zero(input logic [15:0] ext);
    return (ext == `EXT_ZERO_A) || (ext == `EXT_ZERO_B);
  endfunction

  function automatic logic is_special(input logic [6:0] addr);
    return (addr == `PA_EXTENDED_SETTING) || (addr == `PA_TORQUE_SOURCE) || (addr == `PA_TORQUE_RAM)
      || (addr == `PA_TORQUE_RAM_NVM) || (addr == `PA_SET_FREQUENCY) || (addr == `PA_OPMODE);
  endfunction

  // Remote word registers
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      monitor_select_1_2 <= `RW_RESET_VALUE;
      speed_or_torque_setpoint <= `RW_RESET_VALUE;
      instruction_word <= `RW_RESET_VALUE;
      instruction_operand <= `RW_RESET_VALUE;
      monitor_select_3 <= `RW_RESET_VALUE;
      monitor_select_4 <= `RW_RESET_VALUE;
      monitor_select_5 <= `RW_RESET_VALUE;
      monitor_select_6 <= `RW_RESET_VALUE;
    end
    else if (word_write.valid)
    begin
      case (word_write.index) // [R15]
        `RW_MONITOR_SELECT_1_2: monitor_select_1_2 <= word_write.data;
        `RW_SPEED_OR_TORQUE: speed_or_torque_setpoint <= word_write.data;
        `RW_INSTRUCTION_WORD: instruction_word <= word_write.data;
        `RW_INSTRUCTION_OPERAND: instruction_operand <= word_write.data;
        `RW_MONITOR_SELECT_3: monitor_select_3 <= word_write.data;
        `RW_MONITOR_SELECT_4: monitor_select_4 <= word_write.data;
        `RW_MONITOR_SELECT_5: monitor_select_5 <= word_write.data;
        `RW_MONITOR_SELECT_6: monitor_select_6 <= word_write.data;
        default: monitor_select_1_2 <= monitor_select_1_2;
      endcase
    end
  end

  monitor_fill #(
    .ITEMS(ITEMS)
  ) u_monitor_fill (
    .core_clk(core_clk),
    .resetn(resetn),
    .monitor_request(monitor_request),
    .monitor_select_1_2(monitor_select_1_2),
    .monitor_select_3(monitor_select_3),
    .monitor_select_4(monitor_select_4),
    .monitor_select_5(monitor_select_5),
    .monitor_select_6(monitor_select_6),
    .monitor_items(monitor_items),
    .monitor_result_1(monitor_result_1),
    .monitor_result_2(monitor_result_2),
    .monitor_result_5(monitor_result_5),
    .monitor_result_6(monitor_result_6),
    .monitor_result_7(monitor_result_7),
    .monitor_result_8(monitor_result_8),
    .monitoring_flag(monitoring_flag)
  );

  assign torque_mode = ((extended_setting_param == `EXT_TORQUE_A) || (extended_setting_param == `EXT_TORQUE_B)
    || (extended_setting_param == `EXT_TORQUE_C))
    && ((torque_source_param == `SRC_TORQUE_A) || (torque_source_param == `SRC_TORQUE_B)); // [R5]
  assign opcode = instruction_word[`CODE_LO_MSB:`CODE_LO_LSB];
  assign param_addr = opcode[`PARAM_ADDR_MSB:0];
  assign store_we = (state == rwc_pkg::ST_EXECUTE) && opcode[`WRITE_FLAG_BIT] && !is_special(param_addr)
    && opcode != `CMD_OPMODE_WRITE && opcode != `CMD_ERROR_CLEAR;

  param_store #(
    .WIDTH(16),
    .DEPTH(PARAM_DEPTH),
    .AW(7)
  ) u_param_store (
    .core_clk(core_clk),
    .write_enable(store_we),
    .write_addr(param_addr),
    .write_data(instruction_operand),
    .read_addr(param_addr),
    .read_data(store_rdata)
  );

  // Sequencer: one setpoint write or one instruction at a time
  always_comb
  begin
    next_state = state;
    case (state)
      rwc_pkg::ST_IDLE:
      begin
        if ((ram_write_request && !ram_write_done) || (ram_nvm_write_request && !ram_nvm_write_done))
        begin
          next_state = rwc_pkg::ST_SETPOINT;
        end
        else if (execute_request && !execute_done) // [R7]
        begin
          next_state = rwc_pkg::ST_EXECUTE;
        end
      end
      rwc_pkg::ST_SETPOINT: next_state = rwc_pkg::ST_FINISH;
      rwc_pkg::ST_EXECUTE:
      begin
        if (!opcode[`WRITE_FLAG_BIT] && !is_special(param_addr) && opcode != `CMD_ERROR_REFER
          && opcode != `CMD_OPMODE_READ)
        begin
          next_state = rwc_pkg::ST_READ_WAIT;
        end
        else
        begin
          next_state = rwc_pkg::ST_FINISH;
        end
      end
      rwc_pkg::ST_READ_WAIT: next_state = rwc_pkg::ST_FINISH;
      rwc_pkg::ST_FINISH: next_state = rwc_pkg::ST_IDLE;
      default: next_state = rwc_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state <= rwc_pkg::ST_IDLE;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Remembers which write request started the setpoint operation
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      setpoint_to_nvm <= 1'b0;
    end
    else if (state == rwc_pkg::ST_IDLE)
    begin
      setpoint_to_nvm <= !(ram_write_request && !ram_write_done);
    end
  end

  // Setpoint and parameter flip-flops
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      set_frequency <= `PARAM_RESET;
      torque_ram_param <= `PARAM_RESET;
      torque_ram_nvm_param <= `PARAM_RESET;
      extended_setting_param <= `EXT_RESET;
      torque_source_param <= `SRC_RESET;
      operation_mode <= `OPMODE_RESET;
    end
    else if (state == rwc_pkg::ST_SETPOINT)
    begin
      if (torque_mode)
      begin
        torque_ram_param <= speed_or_torque_setpoint; // [R6]
        torque_ram_nvm_param <= speed_or_torque_setpoint; // [R6]
      end
      else
      begin
        set_frequency <= speed_or_torque_setpoint; // [R2] [R4]
      end
    end
    else if (state == rwc_pkg::ST_EXECUTE && opcode[`WRITE_FLAG_BIT])
    begin
      case (opcode)
        `CMD_OPMODE_WRITE: operation_mode <= instruction_operand;
        default:
        begin
          case (param_addr)
            `PA_EXTENDED_SETTING: extended_setting_param <= instruction_operand;
            `PA_TORQUE_SOURCE: torque_source_param <= instruction_operand;
            `PA_TORQUE_RAM: torque_ram_param <= instruction_operand;
            `PA_TORQUE_RAM_NVM: torque_ram_nvm_param <= instruction_operand;
            `PA_SET_FREQUENCY: set_frequency <= instruction_operand;
            default: operation_mode <= operation_mode;
          endcase
        end
      endcase
    end
  end

  // Nonvolatile write pulses
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      nvm_write <= '0;
    end
    else if (state == rwc_pkg::ST_SETPOINT && setpoint_to_nvm)
    begin
      nvm_write.strobe <= 1'b1; // [R2]
      nvm_write.addr <= torque_mode ? `PA_TORQUE_RAM_NVM : `PA_SET_FREQUENCY;
      nvm_write.data <= speed_or_torque_setpoint;
    end
    else if (state == rwc_pkg::ST_EXECUTE && opcode[`WRITE_FLAG_BIT] && opcode != `CMD_ERROR_CLEAR
      && opcode != `CMD_OPMODE_WRITE)
    begin
      nvm_write.strobe <= 1'b1;
      nvm_write.addr <= param_addr;
      nvm_write.data <= instruction_operand;
    end
    else
    begin
      nvm_write.strobe <= 1'b0;
    end
  end

  // Instruction results
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      instruction_reply <= 16'h0000;
      link_extended_setting <= 8'h00;
      fault_reset <= 1'b0;
    end
    else
    begin
      fault_reset <= (state == rwc_pkg::ST_EXECUTE) && (opcode == `CMD_ERROR_CLEAR);
      if (state == rwc_pkg::ST_EXECUTE)
      begin
        link_extended_setting <= ext_is_zero(extended_setting_param) ? 8'h00
          : instruction_word[`CODE_HI_MSB:`CODE_HI_LSB]; // [R9]
        case (opcode) // [R7]
          `CMD_OPMODE_READ: instruction_reply <= operation_mode;
          `CMD_ERROR_REFER: instruction_reply <= fault_code;
          default:
          begin
            case (param_addr)
              `PA_EXTENDED_SETTING: instruction_reply <= extended_setting_param;
              `PA_TORQUE_SOURCE: instruction_reply <= torque_source_param;
              `PA_TORQUE_RAM: instruction_reply <= torque_ram_param;
              `PA_TORQUE_RAM_NVM: instruction_reply <= torque_ram_nvm_param;
              `PA_SET_FREQUENCY: instruction_reply <= set_frequency;
              `PA_OPMODE: instruction_reply <= operation_mode;
              default: instruction_reply <= instruction_reply;
            endcase
          end
        endcase
      end
      else if (state == rwc_pkg::ST_READ_WAIT)
      begin
        instruction_reply <= store_rdata;
      end
    end
  end

  // Completion flags; a flag only sets while its request is high, so set and clear never meet
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ram_write_done <= 1'b0;
      ram_nvm_write_done <= 1'b0;
    end
    else
    begin
      if (!ram_write_request)
      begin
        ram_write_done <= 1'b0; // [R14]
      end
      else if (state == rwc_pkg::ST_FINISH && !setpoint_to_nvm && next_state == rwc_pkg::ST_IDLE
        && !execute_flow)
      begin
        ram_write_done <= 1'b1; // [R3]
      end
      if (!ram_nvm_write_request)
      begin
        ram_nvm_write_done <= 1'b0; // [R14]
      end
      else if (state == rwc_pkg::ST_FINISH && setpoint_to_nvm && !execute_flow)
      begin
        ram_nvm_write_done <= 1'b1; // [R3]
      end
    end
  end

  // Marks that the current operation is an instruction rather than a setpoint
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      execute_flow <= 1'b0;
    end
    else if (state == rwc_pkg::ST_SETPOINT)
    begin
      execute_flow <= 1'b0;
    end
    else if (state == rwc_pkg::ST_EXECUTE)
    begin
      execute_flow <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      execute_done <= 1'b0;
    end
    else if (!execute_request)
    begin
      execute_done <= 1'b0; // [R14]
    end
    else if (state == rwc_pkg::ST_FINISH && execute_flow)
    begin
      execute_done <= 1'b1; // [R8]
    end
  end

endmodule

// *** testbench/rwc_checker_sva.sv ***
`timescale 1ns/1ps
module rwc_checker #(
  parameter int ITEMS = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // Master side
  input rwc_pkg::word_write_s word_write,
  input wire logic monitor_request,
  input wire logic ram_write_request,
  input wire logic ram_nvm_write_request,
  input wire logic execute_request,
  input wire logic [ITEMS*16-1:0] monitor_items,
  // Device side
  input wire logic [15:0] monitor_result_1,
  input wire logic [15:0] monitor_result_5,
  input wire logic monitoring_flag,
  input wire logic ram_write_done,
  input wire logic ram_nvm_write_done,
  input wire logic execute_done,
  input wire logic fault_reset,
  input rwc_pkg::nvm_write_s nvm_write
);
  logic [15:0] w0;
  logic [15:0] w4;
  logic [15:0] exp1;
  logic [15:0] exp5;

  // Shadow of the selection words the results depend on
  always_ff @(posedge core_clk or negedge resetn)
    if (!resetn)
    begin
      w0 <= 16'h0000;
      w4 <= 16'h0000;
    end
    else if (word_write.valid)
    begin
      if (word_write.index == 3'h0)
        w0 <= word_write.data;
      if (word_write.index == 3'h4)
        w4 <= word_write.data;
    end

  assign exp1 = (w0[7:0] < ITEMS) ? monitor_items[w0[7:0]*16 +: 16] : 16'h0000;
  assign exp5 = (w4 < ITEMS) ? monitor_items[w4*16 +: 16] : 16'h0000;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!resetn);

  AST_MON_RESULT_1: assert property (monitor_request |=> monitor_result_1 == $past(exp1))
    else $error("result 1 is not the selected item");
  AST_MON_RESULT_5: assert property (monitor_request |=> monitor_result_5 == $past(exp5))
    else $error("result 5 is not the selected item");
  AST_FLAG_RISE: assert property ($rose(monitor_request) |-> ##1 !monitoring_flag ##1 monitoring_flag)
    else $error("monitoring flag timing wrong");
  AST_FLAG_DROP: assert property ($fell(monitor_request) |=> !monitoring_flag)
    else $error("monitoring flag did not drop");
  AST_RAM_DONE: assert property ($rose(ram_write_request) |-> (!ram_write_done) [*3] ##[1:10] ram_write_done)
    else $error("RAM done timing wrong");
  AST_NVM_DONE: assert property ($rose(ram_nvm_write_request) |-> (!ram_nvm_write_done) [*3] ##[1:10] ram_nvm_write_done)
    else $error("NVM done timing wrong");
  AST_NVM_PULSE: assert property ($rose(ram_nvm_write_request) |-> ##2 nvm_write.strobe ##1 !nvm_write.strobe)
    else $error("NVM store pulse missing");
  AST_EXEC_DONE: assert property ($rose(execute_request) |-> (!execute_done) [*3] ##[1:10] execute_done)
    else $error("execute done timing wrong");
  AST_DONE_FOLLOWS: assert property ((!ram_write_request |=> !ram_write_done) and
    (!ram_nvm_write_request |=> !ram_nvm_write_done) and (!execute_request |=> !execute_done))
    else $error("done flag outlived its request");
  AST_FAULT_PULSE: assert property (fault_reset |-> (execute_request && !execute_done) ##1 !fault_reset)
    else $error("fault reset pulse out of place");
endmodule

bind remote_word_command_handler rwc_checker #(.ITEMS(ITEMS)) u_rwc_checker (
  .core_clk, .resetn, .word_write, .monitor_request, .ram_write_request, .ram_nvm_write_request,
  .execute_request, .monitor_items, .monitor_result_1, .monitor_result_5, .monitoring_flag,
  .ram_write_done, .ram_nvm_write_done, .execute_done, .fault_reset, .nvm_write
);

// *** testbench/fieldbus_master.sv ***
`timescale 1ns/1ps
module fieldbus_master (
  // Clock
  input wire logic core_clk,
  // Word writes and request bits to the device
  output rwc_pkg::word_write_s word_write,
  output logic [3:0] requests,
  // Device flags, same bit order as requests
  input wire logic [3:0] done
);
  initial
  begin
    word_write = '{1'b0, 3'h0, 16'hFFFF};
    requests = 4'h0;
  end

  // Released data is inverted, never stale
  task automatic write_word(input logic [2:0] idx, input logic [15:0] data);
    @(negedge core_clk);
    word_write <= '{1'b1, idx, data};
    @(negedge core_clk);
    word_write <= '{1'b0, idx, ~data};
  endtask

  task automatic handshake(input int n, output int cycles);
    @(negedge core_clk);
    requests[n] <= 1'b1;
    cycles = 0;
    do
    begin
      @(negedge core_clk);
      cycles++;
    end
    while (done[n] !== 1'b1 && cycles < 20);
  endtask

  task automatic release_req(input int n);
    @(negedge core_clk);
    requests[n] <= 1'b0;
  endtask

  task automatic run_instr(input logic [15:0] code, input logic [15:0] operand, output int cycles);
    write_word(3'h2, code);
    write_word(3'h3, operand);
    handshake(3, cycles);
    release_req(3);
    @(negedge core_clk);
  endtask
endmodule

// *** testbench/remote_word_command_handler_tb_top.sv ***
`timescale 1ns/1ps
module remote_word_command_handler_tb_top;
  localparam int ITEMS = 16;
  logic core_clk;
  logic resetn;
  logic [3:0] requests;
  logic [ITEMS*16-1:0] monitor_items;
  logic [15:0] fault_code, res1, res2, res5, res6, res7, res8, reply, freq, tq_ram, tq_nvm, opmode;
  logic flag, ram_done, nvm_done, exec_done, fault_reset;
  logic [7:0] link_ext;
  rwc_pkg::word_write_s word_write;
  rwc_pkg::nvm_write_s nvm_write, nvm_last;
  int bad_count = 0;
  int n_tests = 0;
  int nvm_count = 0, fault_count = 0;

  remote_word_command_handler #(.ITEMS(ITEMS)) DUT (
    .core_clk, .resetn, .word_write, .monitor_request(requests[0]), .ram_write_request(requests[1]),
    .ram_nvm_write_request(requests[2]), .execute_request(requests[3]), .monitor_items, .fault_code,
    .monitor_result_1(res1), .monitor_result_2(res2), .monitor_result_5(res5), .monitor_result_6(res6),
    .monitor_result_7(res7), .monitor_result_8(res8), .monitoring_flag(flag), .ram_write_done(ram_done),
    .ram_nvm_write_done(nvm_done), .execute_done(exec_done), .instruction_reply(reply),
    .link_extended_setting(link_ext), .set_frequency(freq), .torque_ram_param(tq_ram),
    .torque_ram_nvm_param(tq_nvm), .operation_mode(opmode), .fault_reset, .nvm_write
  );

  fieldbus_master u_master (.core_clk, .word_write, .requests, .done({exec_done, nvm_done, ram_done, flag}));

  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // Pulses sampled mid-cycle
  always @(negedge core_clk)
  begin
    if (nvm_write.strobe === 1'b1)
    begin
      nvm_count++;
      nvm_last = nvm_write;
    end
    if (fault_reset === 1'b1)
      fault_count++;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic test_monitor();
    int cyc;
    check(freq, 16'h0000, "reset value");
    u_master.write_word(3'h0, 16'h0F02);
    u_master.write_word(3'h4, 16'h0003);
    u_master.write_word(3'h5, 16'h0010);
    u_master.write_word(3'h6, 16'h0000);
    u_master.write_word(3'h7, 16'h0009);
    u_master.handshake(0, cyc);
    check(16'(cyc), 16'h0002, "flag delay");
    check(res1, 16'hA002, "result 1");
    check(res2, 16'hA00F, "result 2");
    check(res5, 16'hA003, "result 5");
    check(res6, 16'h0000, "result 6");
    check(res7, 16'hA000, "result 7");
    check(res8, 16'hA009, "result 8");
    u_master.release_req(0);
    monitor_items[47:32] = 16'h5555;
    @(negedge core_clk);
    check(16'(flag), 16'h0000, "flag drop");
    check(res1, 16'hA002, "result held");
    $display("monitor test done");
  endtask

  task automatic test_setpoint();
    int cyc;
    u_master.write_word(3'h1, 16'hE678);
    u_master.handshake(1, cyc);
    check(16'(cyc), 16'h0003, "RAM done delay");
    check(freq, 16'hE678, "RAM frequency");
    check(16'(nvm_count), 16'h0000, "no NVM store");
    check(16'(nvm_done), 16'h0000, "other done");
    u_master.release_req(1);
    @(negedge core_clk);
    check(16'(ram_done), 16'h0000, "RAM done drop");
    u_master.write_word(3'h1, 16'h1388);
    u_master.handshake(2, cyc);
    check(16'(cyc), 16'h0003, "NVM done delay");
    check(freq, 16'h1388, "NVM frequency");
    check({9'h000, nvm_last.addr}, 16'h0005, "NVM address");
    check(nvm_last.data, 16'h1388, "NVM data");
    u_master.release_req(2);
    @(negedge core_clk);
    check(16'(nvm_done), 16'h0000, "NVM done drop");
    $display("setpoint test done");
  endtask

  task automatic test_instr();
    int cyc;
    u_master.run_instr(16'h00FD, 16'h0002, cyc);
    check(16'(cyc), 16'h0003, "execute delay");
    check(opmode, 16'h0002, "mode write");
    check(16'(exec_done), 16'h0000, "execute done drop");
    u_master.run_instr(16'h007D, 16'h0000, cyc);
    check(reply, 16'h0002, "mode read");
    check(16'(cyc), 16'h0003, "mode read delay");
    u_master.run_instr(16'h007E, 16'h0000, cyc);
    check(reply, 16'h00C5, "error reference");
    u_master.run_instr(16'h00FE, 16'h0000, cyc);
    check(16'(fault_count), 16'h0001, "error clear");
    u_master.run_instr(16'h00A0, 16'hBEEF, cyc);
    u_master.run_instr(16'h0020, 16'h0000, cyc);
    check(16'(cyc), 16'h0004, "memory read delay");
    check(reply, 16'hBEEF, "memory read");
    $display("instruction test done");
  endtask

  task automatic test_ext();
    logic [15:0] ext_v [3] = '{16'h0000, 16'h0064, 16'h0001};
    logic [7:0] exp_v [3] = '{8'h00, 8'h00, 8'h3C};
    int cyc;
    for (int i = 0; i < 3; i++)
    begin
      u_master.run_instr(16'h0081, ext_v[i], cyc);
      u_master.run_instr(16'h3C7D, 16'h0000, cyc);
      check({8'h00, link_ext}, {8'h00, exp_v[i]}, "link setting");
    end
    $display("extended setting test done");
  endtask

  task automatic test_torque();
    logic [15:0] ext_v [4] = '{16'h0000, 16'h0001, 16'h000C, 16'h0064};
    logic [15:0] src_v [4] = '{16'h0003, 16'h0005, 16'h0003, 16'h0005};
    logic [15:0] v;
    int cyc;
    for (int i = 0; i < 4; i++)
    begin
      v = 16'h1230 + 16'(i);
      u_master.run_instr(16'h0081, ext_v[i], cyc);
      u_master.run_instr(16'h0082, src_v[i], cyc);
      u_master.write_word(3'h1, v);
      u_master.handshake(1 + i % 2, cyc);
      check(freq, i < 3 ? 16'h1388 : v, "frequency");
      check(tq_ram, i < 3 ? v : 16'h1232, "torque RAM");
      check(tq_nvm, i < 3 ? v : 16'h1232, "torque NVM");
      u_master.release_req(1 + i % 2);
    end
    $display("torque test done");
  endtask

  initial
  begin
    resetn = 1'b0;
    fault_code = 16'h00C5;
    for (int i = 0; i < ITEMS; i++)
      monitor_items[i*16 +: 16] = 16'hA000 + 16'(i);
    repeat (12) @(negedge core_clk);
    resetn = 1'b1;
    @(negedge core_clk);
    test_monitor();
    test_setpoint();
    test_instr();
    test_ext();
    test_torque();
    final_report();
  end

  initial
  begin
    #(25 * 6000);
    bad_count++;
    $display("watchdog expired");
    final_report();
  end
endmodule
